// ==== rtl/cpm_defs.svh ====
// timing, reset and field constants of the memory-bus interface
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
`define CPM_CLK_PS 8000
`define CPM_HALF_T_NS 8
`define CPM_HALF_T_CYC (((`CPM_HALF_T_NS * 1000) + `CPM_CLK_PS - 1) / `CPM_CLK_PS)
`define CPM_RD3_STB_CYC (3 * `CPM_HALF_T_CYC)
`define CPM_RD4_STB_CYC (4 * `CPM_HALF_T_CYC)
`define CPM_WR_STB_CYC (3 * `CPM_HALF_T_CYC)
`define CPM_IWR_CYC (2 * `CPM_HALF_T_CYC)
`define CPM_RIC_RST 8'h01
`define CPM_MS_LSB 0
`define CPM_MS_IMEM 2'h1
`define CPM_MS_PC_LO 2'h2
`define CPM_MS_PC_HI 2'h3
`define CPM_RPIN_IDLE 12'hC00
`endif

// ==== rtl/cpm_pkg.sv ====
// types of the memory-bus interface
package cpm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ALE = 3'h1, ST_AHOLD = 3'h2, ST_EXTRA = 3'h3,
    ST_STROBE = 3'h4, ST_RECOV = 3'h5, ST_TURN = 3'h6, ST_REMOTE = 3'h7
  } cpm_state_t;
  typedef struct packed {
    logic [15:0] a;
    logic a_oe;
    logic [7:0] ad;
    logic ad_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
  } cpm_dbus_t;
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic sel;
    logic dm_req;
    logic [7:0] data;
  } cpm_rpin_t;
endpackage

// ==== rtl/cpm_mem_bus_if.sv ====
// memory-bus interface: data-memory cycles, bus handover, remote program access
// Behaviour
// - four-state select gives 4 T-state reads
// - reset or zero gives 3 T-state reads
// - half T-state after read before driving AD
// - half T-state high-impedance on bus handover
// - soft-load address increments after write, in phase
// - local indication released on remote read rise
// - reset clears index, zeroes A and AD
// - selecting instruction memory restarts at low byte
// - simultaneous data-memory requests: local wins first
// - then alternate owners unless locked
// - reset selects instruction memory
`timescale 1ns/1ps
`include "cpm_defs.svh"
module cpm_mem_bus_if (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic core_req_in,
  input wire logic core_wr_in,
  input wire logic [15:0] core_addr_in,
  input wire logic [7:0] core_wdata_in,
  input wire logic core_lock_in,
  input wire logic core_idle_in,
  input wire logic acr_wr_in,
  input wire logic acr_4tr_in,
  output logic core_ready_out,
  output logic core_done_out,
  output logic [7:0] core_rdata_out,
  output logic index_clear_out,
  output cpm_pkg::cpm_dbus_t dbus_out,
  input wire logic [7:0] ad_in,
  input wire cpm_pkg::cpm_rpin_t rpin_in,
  output logic rem_grant_out,
  output logic [7:0] rem_data_out,
  output logic rem_data_oe_out,
  output logic local_access_indication_n_out,
  output logic [15:0] instruction_address_bus_out,
  input wire logic [15:0] imem_d_in,
  output logic [15:0] imem_d_out,
  output logic instruction_write_strobe_n_out
);
  import cpm_pkg::*;

  function automatic logic [7:0] sel_byte(input logic [15:0] w, input logic hi);
    sel_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================
  // remote pin synchroniser
  cpm_rpin_t rp1_q, rp_s_q;
  logic prev_rd_q, prev_wr_q;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rp1_q <= `CPM_RPIN_IDLE;
      rp_s_q <= `CPM_RPIN_IDLE;
      prev_rd_q <= 1'b1;
      prev_wr_q <= 1'b1;
    end else begin
      rp1_q <= rpin_in;
      rp_s_q <= rp1_q;
      prev_rd_q <= rp_s_q.rd_n;
      prev_wr_q <= rp_s_q.wr_n;
    end
  end
  logic rd_fall, rd_rise, wr_fall, wr_rise, rem_req;
  assign rd_fall = prev_rd_q & ~rp_s_q.rd_n;
  assign rd_rise = ~prev_rd_q & rp_s_q.rd_n;
  assign wr_fall = prev_wr_q & ~rp_s_q.wr_n;
  assign wr_rise = ~prev_wr_q & rp_s_q.wr_n;
  assign rem_req = rp_s_q.dm_req;

  // ==========================================================
  // data-memory cycle and bus ownership
  cpm_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic wr_cyc_q, wr_cyc_d, cyc4_q, cyc4_d, owner_q, owner_d;
  logic last_rem_q, last_rem_d, first_q, first_d, fts_q, fts_d;
  logic done_q, done_d, idx_clr_q;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
  cpm_dbus_t dbus_q, dbus_d;
  logic go_local;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_cyc_d = wr_cyc_q;
    cyc4_d = cyc4_q;
    owner_d = owner_q;
    last_rem_d = last_rem_q;
    first_d = first_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    fts_d = acr_wr_in ? acr_4tr_in : fts_q;
    go_local = core_req_in & (~rem_req | ~first_q | last_rem_q | core_lock_in);
    unique case (st_q)
      ST_IDLE: begin
        if (go_local) begin
          st_d = ST_ALE;
          addr_d = core_addr_in;
          wdata_d = core_wdata_in;
          wr_cyc_d = core_wr_in;
          cyc4_d = fts_q & ~core_wr_in;
          last_rem_d = 1'b0;
          first_d = 1'b1;
        end else if (rem_req & ~core_lock_in) begin
          st_d = ST_TURN;
          owner_d = 1'b1;
          last_rem_d = 1'b1;
          first_d = 1'b1;
        end
      end
      ST_ALE: st_d = ST_AHOLD;
      ST_AHOLD: begin
        st_d = cyc4_q ? ST_EXTRA : ST_STROBE;
        cnt_d = wr_cyc_q ? 3'(`CPM_WR_STB_CYC) :
                cyc4_q ? 3'(`CPM_RD4_STB_CYC) : 3'(`CPM_RD3_STB_CYC);
      end
      ST_EXTRA: st_d = ST_STROBE;
      ST_STROBE: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          st_d = ST_RECOV;
          if (!wr_cyc_q) begin
            rdata_d = ad_in;
          end
        end
      end
      ST_RECOV: begin
        st_d = ST_IDLE;
        done_d = 1'b1;
      end
      ST_TURN: st_d = owner_q ? ST_REMOTE : ST_IDLE;
      ST_REMOTE: begin
        if (!rem_req) begin
          st_d = ST_TURN;
          owner_d = 1'b0;
        end
      end
    endcase
    dbus_d.a = addr_d;
    dbus_d.a_oe = (st_d != ST_TURN) && (st_d != ST_REMOTE);
    dbus_d.ad = (st_d == ST_ALE || st_d == ST_AHOLD) ? addr_d[7:0] :
                (st_d == ST_IDLE) ? 8'h00 : wdata_d;
    dbus_d.ad_oe = (st_d == ST_IDLE) || (st_d == ST_ALE) || (st_d == ST_AHOLD) ||
                   (wr_cyc_d && (st_d == ST_STROBE || st_d == ST_RECOV));
    dbus_d.ale = (st_d == ST_ALE);
    dbus_d.rd_n = ~((st_d == ST_STROBE) & ~wr_cyc_d);
    dbus_d.wr_n = ~((st_d == ST_STROBE) & wr_cyc_d);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      wr_cyc_q <= 1'b0;
      cyc4_q <= 1'b0;
      owner_q <= 1'b0;
      last_rem_q <= 1'b0;
      first_q <= 1'b0;
      fts_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      dbus_q <= '{a: 16'h0000, a_oe: 1'b1, ad: 8'h00, ad_oe: 1'b1,
                  ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
      idx_clr_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_cyc_q <= wr_cyc_d;
      cyc4_q <= cyc4_d;
      owner_q <= owner_d;
      last_rem_q <= last_rem_d;
      first_q <= first_d;
      fts_q <= fts_d;
      done_q <= done_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      dbus_q <= dbus_d;
      idx_clr_q <= 1'b0;
    end
  end

  // ==========================================================
  // remote configuration, program counter and instruction memory
  logic [7:0] ric_q, ric_d, lo_q, lo_d, rrd_q, rrd_d;
  logic [15:0] ia_q, ia_d, iwd_q, iwd_d;
  logic hi_q, hi_d, roe_q, roe_d, lcl_n_q, lcl_n_d, act_q, act_d, iwr_n_q, iwr_n_d;
  logic [1:0] icnt_q, icnt_d, ms;
  logic acc_ok;
  assign ms = ric_q[`CPM_MS_LSB +: 2];
  assign acc_ok = rp_s_q.sel | core_idle_in;

  always_comb begin
    ric_d = ric_q;
    lo_d = lo_q;
    rrd_d = rrd_q;
    ia_d = ia_q;
    iwd_d = iwd_q;
    hi_d = hi_q;
    roe_d = roe_q;
    lcl_n_d = lcl_n_q;
    act_d = act_q;
    iwr_n_d = iwr_n_q;
    icnt_d = icnt_q;
    if (icnt_q != 2'h0) begin
      icnt_d = icnt_q - 2'h1;
      if (icnt_q == 2'h1) begin
        iwr_n_d = 1'b1;
        ia_d = ia_q + 16'h0001;
      end
    end
    if (rd_fall | wr_fall) begin
      act_d = acc_ok;
      lcl_n_d = ~acc_ok;
    end
    if (rd_fall & acc_ok) begin
      roe_d = 1'b1;
      unique case (ms)
        2'h0: rrd_d = 8'h00;
        `CPM_MS_IMEM: rrd_d = sel_byte(imem_d_in, hi_q);
        `CPM_MS_PC_LO: rrd_d = sel_byte(ia_q, 1'b0);
        `CPM_MS_PC_HI: rrd_d = sel_byte(ia_q, 1'b1);
      endcase
      if (rp_s_q.sel) begin
        rrd_d = ric_q;
      end
    end
    if (rd_rise & act_q) begin
      lcl_n_d = 1'b1;
      roe_d = 1'b0;
      act_d = 1'b0;
      if (!rp_s_q.sel && ms == `CPM_MS_IMEM) begin
        hi_d = ~hi_q;
        if (hi_q) begin
          ia_d = ia_q + 16'h0001;
        end
      end
    end
    if (wr_rise & act_q) begin
      lcl_n_d = 1'b1;
      act_d = 1'b0;
      if (rp_s_q.sel) begin
        ric_d = rp_s_q.data;
        if (rp_s_q.data[`CPM_MS_LSB +: 2] == `CPM_MS_IMEM) begin
          hi_d = 1'b0;
        end
      end else begin
        unique case (ms)
          2'h0: ;
          `CPM_MS_IMEM: begin
            if (!hi_q) begin
              lo_d = rp_s_q.data;
              hi_d = 1'b1;
            end else begin
              iwd_d = {rp_s_q.data, lo_q};
              icnt_d = 2'(`CPM_IWR_CYC);
              iwr_n_d = 1'b0;
              hi_d = 1'b0;
            end
          end
          `CPM_MS_PC_LO: ia_d[7:0] = rp_s_q.data;
          `CPM_MS_PC_HI: ia_d[15:8] = rp_s_q.data;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ric_q <= `CPM_RIC_RST;
      lo_q <= 8'h00;
      rrd_q <= 8'h00;
      ia_q <= 16'h0000;
      iwd_q <= 16'h0000;
      hi_q <= 1'b0;
      roe_q <= 1'b0;
      lcl_n_q <= 1'b1;
      act_q <= 1'b0;
      iwr_n_q <= 1'b1;
      icnt_q <= 2'h0;
    end else begin
      ric_q <= ric_d;
      lo_q <= lo_d;
      rrd_q <= rrd_d;
      ia_q <= ia_d;
      iwd_q <= iwd_d;
      hi_q <= hi_d;
      roe_q <= roe_d;
      lcl_n_q <= lcl_n_d;
      act_q <= act_d;
      iwr_n_q <= iwr_n_d;
      icnt_q <= icnt_d;
    end
  end

  // ==========================================================
  // outputs
  assign core_ready_out = (st_q == ST_IDLE);
  assign core_done_out = done_q;
  assign core_rdata_out = rdata_q;
  assign index_clear_out = idx_clr_q;
  assign dbus_out = dbus_q;
  assign rem_grant_out = (st_q == ST_REMOTE);
  assign rem_data_out = rrd_q;
  assign rem_data_oe_out = roe_q;
  assign local_access_indication_n_out = lcl_n_q;
  assign instruction_address_bus_out = ia_q;
  assign imem_d_out = iwd_q;
  assign instruction_write_strobe_n_out = iwr_n_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  rd_four_a: assert property ($fell(dbus_q.rd_n) && cyc4_q |->
                              (!dbus_q.rd_n)[*4] ##1 dbus_q.rd_n)
    else $error("4 T-state read strobe length wrong");
  rd_three_a: assert property ($fell(dbus_q.rd_n) && !cyc4_q |->
                               (!dbus_q.rd_n)[*3] ##1 dbus_q.rd_n)
    else $error("3 T-state read strobe length wrong");
  ad_gap_a: assert property ($rose(dbus_q.rd_n) |-> !dbus_q.ad_oe ##1 dbus_q.ad_oe)
    else $error("AD driven too soon after read");
  hand_hiz_a: assert property ($changed(owner_q) |-> !dbus_q.a_oe && !dbus_q.ad_oe)
    else $error("bus handover without gap");
  ia_phase_a: assert property ($rose(iwr_n_q) |-> ia_q == $past(ia_q) + 16'h0001)
    else $error("soft-load address not advanced");
  lcl_free_a: assert property (rd_rise && act_q |=> lcl_n_q && !roe_q)
    else $error("local indication held after read");
  rst_zero_a: assert property (idx_clr_q |-> dbus_q.a == 16'h0000 && dbus_q.ad == 8'h00)
    else $error("buses not zero after reset");
  ric_low_a: assert property (wr_rise && act_q && rp_s_q.sel &&
                              rp_s_q.data[1:0] == `CPM_MS_IMEM |=> !hi_q)
    else $error("byte pointer not reset");
  prio_loc_a: assert property (st_q == ST_IDLE && core_req_in && rem_req && !first_q
                               |=> st_q == ST_ALE)
    else $error("local not first");
  alt_rem_a: assert property (st_q == ST_IDLE && core_req_in && rem_req && first_q &&
                              !last_rem_q && !core_lock_in |=> st_q == ST_TURN ##1 rem_grant_out)
    else $error("owners not alternated");
  ms_rst_a: assert property (idx_clr_q |-> ms == `CPM_MS_IMEM)
    else $error("reset target not instruction memory");
  fts_hold_a: assert property (!acr_wr_in |=> $stable(fts_q))
    else $error("four-state select changed unasked");
  four_rd_c: cover property ($fell(dbus_q.rd_n) && cyc4_q);
  rem_own_c: cover property ($rose(rem_grant_out));
  iwr_c: cover property ($rose(iwr_n_q));
  alt_c: cover property (st_q == ST_IDLE && core_req_in && rem_req && first_q);
endmodule

// ==== testbench/cpm_mem_model.sv ====
// static memory model for the data and instruction buses
`timescale 1ns/1ps
module cpm_mem_model (
  input wire logic clk_in,
  input wire cpm_pkg::cpm_dbus_t dbus_in,
  input wire logic [15:0] ia_in,
  output logic [7:0] ad_out,
  output logic [15:0] imem_d_out
);
  import cpm_pkg::*;
  logic [7:0] mem_q [0:255];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  // low address latched while ALE is high; writes stored while the strobe is low
  always @(posedge clk_in) begin
    if (dbus_in.ale) begin
      lat_q <= dbus_in.ad;
    end
    if (!dbus_in.wr_n) begin
      mem_q[lat_q] <= dbus_in.ad;
    end
    last_q <= ad_out;
  end
  // released bus shows a pattern that changes every cycle
  assign ad_out = !dbus_in.rd_n ? mem_q[lat_q] : ~last_q;
  assign imem_d_out = {~ia_in[7:0], ia_in[7:0] ^ 8'h3C};
endmodule

// ==== testbench/cpu_memory_bus_interface_bench.sv ====
// self-checking bench of the memory-bus interface
`timescale 1ns/1ps
module cpu_memory_bus_interface_bench;
  import cpm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, lock = 1'b0, idle = 1'b0;
  logic acr_wr = 1'b0, acr_v = 1'b0, ready, done, iclr, grant, roe, lcl_n, iwr_n;
  logic [15:0] addr = 16'h0000, ia, imd, imo;
  logic [7:0] wd = 8'h00, rdata, ad, rdo;
  cpm_dbus_t db;
  cpm_rpin_t rp = 12'hC00;
  logic gap_oe, prd, ex_iwr;
  logic [15:0] ex_ia;
  int mismatches = 0, num_checks = 0, cycles = 0, n;
  always #4 clk = ~clk;
  cpm_mem_bus_if cpm_mem_bus_if_inst (.ref_clk_in(clk), .rst_in(rst), .core_req_in(req),
    .core_wr_in(wr), .core_addr_in(addr), .core_wdata_in(wd), .core_lock_in(lock),
    .core_idle_in(idle), .acr_wr_in(acr_wr), .acr_4tr_in(acr_v), .core_ready_out(ready),
    .core_done_out(done), .core_rdata_out(rdata), .index_clear_out(iclr), .dbus_out(db),
    .ad_in(ad), .rpin_in(rp), .rem_grant_out(grant), .rem_data_out(rdo),
    .rem_data_oe_out(roe), .local_access_indication_n_out(lcl_n),
    .instruction_address_bus_out(ia), .imem_d_in(imd), .imem_d_out(imo),
    .instruction_write_strobe_n_out(iwr_n));
  cpm_mem_model cpm_mem_model_inst (.clk_in(clk), .dbus_in(db), .ia_in(ia), .ad_out(ad),
    .imem_d_out(imd));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  // one local cycle; n counts edges from take to done
  task automatic core_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= {8'h00, a};
    wd <= d;
    do @(negedge clk); while (!ready);
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    prd = 1'b1;
    gap_oe = 1'b1;
    do begin
      @(negedge clk);
      n++;
      if (db.rd_n && !prd) begin
        gap_oe = db.ad_oe;
      end
      prd = db.rd_n;
    end while (!done && n < 20);
  endtask
  task automatic set_4tr(input logic v);
    @(posedge clk);
    acr_wr <= 1'b1;
    acr_v <= v;
    @(posedge clk);
    acr_wr <= 1'b0;
  endtask
  // remote strobe, on the register port when s is set; target and data held past the strobe
  task automatic rstb(input logic w, input logic s, input logic [7:0] d);
    @(posedge clk);
    rp <= {w, !w, s, 1'b0, d};
    repeat (6) @(posedge clk);
    rp.rd_n <= 1'b1;
    rp.wr_n <= 1'b1;
    @(negedge clk);
    chk("lcl low", {15'h0000, !(s | idle)}, {15'h0000, lcl_n});
    chk("roe on", {15'h0000, !w & (s | idle)}, {15'h0000, roe});
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lcl_n !== 1'b1 && n < 8);
    ex_iwr = iwr_n;
    ex_ia = ia;
    chk("lcl rel", 16'h0001, {15'h0000, n <= 4});
    chk("roe off", 16'h0000, {15'h0000, roe});
    @(posedge clk);
    rp <= 12'hC00;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset();
    chk("a", 16'h0000, db.a);
    chk("ad", 16'h0000, {8'h00, db.ad});
    chk("iclr", 16'h0001, {15'h0000, iclr});
    chk("ia", 16'h0000, ia);
    $display("test reset done");
  endtask
  // n is the cycle length in clocks plus one for the registered done
  task automatic t_reads();
    core_op(1'b1, 8'h12, 8'h5C);
    chk("wr lat", 16'h0007, n[15:0]);
    core_op(1'b0, 8'h12, 8'h00);
    chk("rd3 lat", 16'h0007, n[15:0]);
    chk("rdata", 16'h005C, {8'h00, rdata});
    chk("ad off", 16'h0000, {15'h0000, gap_oe});
    chk("ad back", 16'h0001, {15'h0000, db.ad_oe});
    set_4tr(1'b1);
    core_op(1'b0, 8'h12, 8'h00);
    chk("rd4 lat", 16'h0009, n[15:0]);
    chk("ad off4", 16'h0000, {15'h0000, gap_oe});
    core_op(1'b0, 8'h12, 8'h00);
    chk("rd4 hold", 16'h0009, n[15:0]);
    chk("rdata4", 16'h005C, {8'h00, rdata});
    set_4tr(1'b0);
    core_op(1'b0, 8'h12, 8'h00);
    chk("rd3 back", 16'h0007, n[15:0]);
    $display("test reads done");
  endtask
  // reset again, then both sides ask together: local first, then remote,
  // with a bus gap each way; a lock then keeps the remote side out
  task automatic t_arb();
    logic seen_done, pg, pa;
    seen_done = 1'b0;
    pg = 1'b0;
    pa = 1'b1;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    rst <= 1'b0;
    rp.dm_req <= 1'b1;
    repeat (2) @(posedge clk);
    req <= 1'b1;
    wr <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (grant && !pg) begin
        chk("first", 16'h0001, {15'h0000, seen_done});
        chk("gap in", 16'h0000, {15'h0000, pa});
      end
      if (done) begin
        chk("alternate", 16'h0000, {15'h0000, seen_done});
        seen_done = 1'b1;
      end
      pg = grant;
      pa = db.a_oe | db.ad_oe;
    end while (!grant && n < 40);
    chk("granted", 16'h0001, {15'h0000, grant});
    @(posedge clk);
    req <= 1'b0;
    rp.dm_req <= 1'b0;
    do @(negedge clk); while (grant && n++ < 60);
    chk("gap out", 16'h0000, {15'h0000, db.a_oe | db.ad_oe});
    @(negedge clk);
    chk("drive back", 16'h0001, {15'h0000, db.a_oe & db.ad_oe});
    @(posedge clk);
    lock <= 1'b1;
    rp.dm_req <= 1'b1;
    repeat (12) @(posedge clk);
    rp.dm_req <= 1'b0;
    @(negedge clk);
    chk("locked", 16'h0000, {15'h0000, grant});
    repeat (4) @(posedge clk);
    lock <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test arbitration done");
  endtask
  // refused while busy, byte order, pointer restart, soft load, counter access
  task automatic t_remote();
    rstb(1'b0, 1'b0, 8'h00);
    chk("refused", 16'h0000, {8'h00, rdo});
    idle <= 1'b1;
    rstb(1'b1, 1'b1, 8'h01);
    rstb(1'b0, 1'b0, 8'h00);
    chk("im lo", {8'h00, 8'h3C}, {8'h00, rdo});
    rstb(1'b0, 1'b0, 8'h00);
    chk("im hi", 16'h00FF, {8'h00, rdo});
    chk("ia inc", 16'h0001, ia);
    rstb(1'b0, 1'b0, 8'h00);
    rstb(1'b1, 1'b1, 8'h01);
    rstb(1'b0, 1'b0, 8'h00);
    chk("im lo2", 16'h003D, {8'h00, rdo});
    rstb(1'b1, 1'b1, 8'h01);
    rstb(1'b1, 1'b0, 8'hA5);
    rstb(1'b1, 1'b0, 8'h5A);
    chk("iw word", 16'h5AA5, imo);
    chk("iw strobe", 16'h0000, {15'h0000, ex_iwr});
    chk("ia held", 16'h0001, ex_ia);
    chk("ia next", 16'h0002, ia);
    chk("iw end", 16'h0001, {15'h0000, iwr_n});
    rstb(1'b1, 1'b1, 8'h03);
    rstb(1'b1, 1'b0, 8'h12);
    rstb(1'b0, 1'b0, 8'h00);
    chk("pc hi", 16'h0012, {8'h00, rdo});
    chk("pc", 16'h1202, ia);
    rstb(1'b1, 1'b1, 8'h02);
    rstb(1'b0, 1'b0, 8'h00);
    chk("pc lo", 16'h0002, {8'h00, rdo});
    rstb(1'b1, 1'b1, 8'h00);
    rstb(1'b0, 1'b0, 8'h00);
    chk("dm port", 16'h0000, {8'h00, rdo});
    $display("test remote done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    t_reset();
    rst <= 1'b0;
    t_reads();
    t_arb();
    t_remote();
    finish_test();
  end
endmodule
